// ==== design/pipelined_burst_sram_port.sv ====
// Pipelined burst SRAM port with write queue
`timescale 1ns/1ps
`include "sram_port_defs.svh"

// --------------------------------------------------
// Write queue
// --------------------------------------------------
module sram_write_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = `SRAM_FIFO_DEPTH
)
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0] wp_r;
    logic [PW-1:0] rp_r;
    logic [PW:0] cnt_r;
    wire push_w = in_valid_in && in_ready_out;
    wire pop_w = out_valid_out && out_ready_in;

    assign in_ready_out = (cnt_r != (PW+1)'(DEPTH));
    assign out_valid_out = (cnt_r != '0);
    assign out_data_out = mem_r[rp_r];

    always_ff @(posedge clk_in)
    begin
        if (push_w)
        begin
            mem_r[wp_r] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            if (push_w)
            begin
                wp_r <= (wp_r == PW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
            end
            if (pop_w)
            begin
                rp_r <= (rp_r == PW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + (PW+1)'(push_w) - (PW+1)'(pop_w);
        end
    end
endmodule : sram_write_fifo

// --------------------------------------------------
// Port top
// --------------------------------------------------
module pipelined_burst_sram_port
    import sram_port_pkg::*;
#(
    parameter int ADDR_W = `SRAM_ADDR_W,
    parameter int FIFO_DEPTH = `SRAM_FIFO_DEPTH
)
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic read_not_write_in,
    input wire logic step_or_load_sel_in,
    input wire logic clk_hold_n_in,
    input wire logic chip_select_low_a_in,
    input wire logic chip_select_low_b_in,
    input wire logic chip_select_high_in,
    input wire logic [`SRAM_LANES-1:0] byte_write_n_in,
    input wire logic burst_order_sel_in,
    input wire logic output_drive_n_in,
    input wire word_t data_in,
    output word_t data_out,
    output logic data_oe_n_out,
    output logic wq_ready_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    // --------------------------------------------------
    // Command decode
    // --------------------------------------------------
    burst_st_t burst_st_r;
    logic [`SRAM_BURST_W-1:0] cnt_r;
    logic [ADDR_W-1:0] base_r;
    stage_t s1_r;
    stage_t s2_r;
    stage_t s3_r;
    word_t data_r;
    logic drive_r;
    word_t mem_r [2**ADDR_W];

    wire en_w = !clk_hold_n_in && wq_ready_out;
    wire sel_w = !chip_select_low_a_in && !chip_select_low_b_in && chip_select_high_in;
    wire load_w = en_w && !step_or_load_sel_in && sel_w;
    wire stop_w = en_w && !step_or_load_sel_in && !sel_w;
    wire in_burst_w = (burst_st_r != BURST_IDLE);
    wire step_w = en_w && step_or_load_sel_in && in_burst_w;
    wire [`SRAM_BURST_W-1:0] cnt_nxt = cnt_r + 1'b1;
    wire [`SRAM_BURST_W-1:0] lin_w = base_r[`SRAM_BURST_W-1:0] + cnt_nxt;
    wire [`SRAM_BURST_W-1:0] ilv_w = base_r[`SRAM_BURST_W-1:0] ^ cnt_nxt;
    wire [`SRAM_BURST_W-1:0] low_w = burst_order_sel_in ? ilv_w : lin_w;
    wire [ADDR_W-1:0] step_addr_w = {base_r[ADDR_W-1:`SRAM_BURST_W], low_w};
    wire step_wr_w = (burst_st_r == BURST_WRITE);

    stage_t s1_nxt;
    always_comb
    begin
        s1_nxt.vld = load_w || step_w;
        s1_nxt.wr = load_w ? !read_not_write_in : step_wr_w;
        s1_nxt.addr = load_w ? addr_in : step_addr_w;
        s1_nxt.bw_n = byte_write_n_in;
    end

    // --------------------------------------------------
    // Burst state
    // --------------------------------------------------
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            burst_st_r <= BURST_IDLE;
            cnt_r <= `SRAM_CNT_RST;
            base_r <= '0;
        end
        else if (en_w)
        begin
            case (burst_st_r)
                default:
                begin
                    if (load_w)
                    begin
                        burst_st_r <= read_not_write_in ? BURST_READ : BURST_WRITE;
                        base_r <= addr_in;
                        cnt_r <= `SRAM_CNT_RST;
                    end
                    else if (stop_w)
                    begin
                        burst_st_r <= BURST_IDLE;
                    end
                    else if (step_w)
                    begin
                        cnt_r <= cnt_nxt;
                    end
                end
            endcase
        end
    end

    // --------------------------------------------------
    // Command pipeline
    // --------------------------------------------------
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end
        else if (en_w)
        begin
            s1_r <= s1_nxt;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // --------------------------------------------------
    // Write queue and array
    // --------------------------------------------------
    function automatic word_t merge(input word_t old_w, input word_t new_w, input logic [`SRAM_LANES-1:0] bw_n);
        word_t res;
        res = old_w;
        for (int i = 0; i < `SRAM_LANES; i++)
        begin
            if (!bw_n[i])
            begin
                res.dat[i*`SRAM_LANE_W +: `SRAM_LANE_W] = new_w.dat[i*`SRAM_LANE_W +: `SRAM_LANE_W];
                res.par[i] = new_w.par[i];
            end
        end
        return res;
    endfunction : merge

    wr_cmd_t push_cmd_w;
    wr_cmd_t head_cmd_w;
    logic head_vld_w;
    wire push_w = en_w && s3_r.vld && s3_r.wr;
    assign push_cmd_w = '{addr: s3_r.addr, bw_n: s3_r.bw_n, wd: data_in};

    sram_write_fifo #(
        .WIDTH($bits(wr_cmd_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_wq (
        .clk_in(mclk_in),
        .rst_in(rst_in),
        .in_valid_in(push_w),
        .in_ready_out(wq_ready_out),
        .in_data_in(push_cmd_w),
        .out_valid_out(head_vld_w),
        .out_ready_in(!clk_hold_n_in),
        .out_data_out(head_cmd_w)
    );

    always_ff @(posedge mclk_in)
    begin
        if (head_vld_w && !clk_hold_n_in)
        begin
            mem_r[head_cmd_w.addr] <= merge(mem_r[head_cmd_w.addr], head_cmd_w.wd, head_cmd_w.bw_n);
        end
    end

    // Read sees queued and in-flight writes
    word_t rd_arr_w;
    word_t rd_q_w;
    word_t rd_w;
    assign rd_arr_w = mem_r[s2_r.addr];
    assign rd_q_w = (head_vld_w && head_cmd_w.addr == s2_r.addr) ?
        merge(rd_arr_w, head_cmd_w.wd, head_cmd_w.bw_n) : rd_arr_w;
    assign rd_w = (push_w && s3_r.addr == s2_r.addr) ? merge(rd_q_w, data_in, s3_r.bw_n) : rd_q_w;

    // --------------------------------------------------
    // Output stage
    // --------------------------------------------------
    wire rd_due_w = s2_r.vld && !s2_r.wr;

    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            drive_r <= `SRAM_DRIVE_RST;
            data_r <= '0;
        end
        else if (en_w)
        begin
            drive_r <= rd_due_w;
            if (rd_due_w)
            begin
                data_r <= rd_w;
            end
        end
    end

    assign data_out = data_r;
    assign data_oe_n_out = !(drive_r && !output_drive_n_in);

    // --------------------------------------------------
    // Checks
    // --------------------------------------------------
    sequence s_load_rd;
        load_w && read_not_write_in;
    endsequence

    sequence s_two_en;
        en_w ##1 en_w;
    endsequence

    sequence s_desel;
        stop_w;
    endsequence

    a_select_decode: assert property (en_w && !step_or_load_sel_in &&
        !(!chip_select_low_a_in && !chip_select_low_b_in && chip_select_high_in) |=> !s1_r.vld)
        else $error("deselected edge started a transfer");
    a_select_load: assert property (en_w && !step_or_load_sel_in &&
        !chip_select_low_a_in && !chip_select_low_b_in && chip_select_high_in |=> s1_r.vld)
        else $error("selected load did not start a transfer");
    a_read_latency: assert property (s_load_rd ##1 s_two_en |=> drive_r && (data_oe_n_out == output_drive_n_in))
        else $error("read data not driven two cycles after load");
    a_read_addr: assert property (s_load_rd ##1 en_w |=> s2_r.addr == $past(addr_in, 2))
        else $error("read pipeline lost load address");
    a_burst_step: assert property (step_w |=> cnt_r == $past(cnt_nxt))
        else $error("burst counter did not advance");
    a_burst_dir: assert property (step_w |=> burst_st_r == $past(burst_st_r) && s1_r.wr == $past(step_wr_w))
        else $error("burst direction changed");
    a_stop_burst: assert property (s_desel |=> burst_st_r == BURST_IDLE)
        else $error("deselect did not end burst");
    a_deselect_hiz: assert property (s_desel ##1 s_two_en |=> !drive_r)
        else $error("bus driven two cycles after deselect");
    a_suspend_hold: assert property (!en_w |=> $stable(data_r) && $stable(drive_r) && $stable(cnt_r))
        else $error("held edge changed state");
    a_reset_hiz: assert property (disable iff (1'b0) rst_in |=> data_oe_n_out)
        else $error("outputs driven after reset");
    a_oe_gate: assert property (output_drive_n_in |-> data_oe_n_out)
        else $error("pins driven with output drive high");
    a_noop_hiz: assert property (en_w && step_or_load_sel_in && !in_burst_w ##1 s_two_en |=> !drive_r)
        else $error("no-op drove the bus");
endmodule : pipelined_burst_sram_port

// ==== design/sram_port_defs.svh ====
// Constants of the pipelined burst SRAM port
`ifndef SRAM_PORT_DEFS_SVH
`define SRAM_PORT_DEFS_SVH
`define SRAM_ADDR_W 17
`define SRAM_DATA_W 32
`define SRAM_LANES 4
`define SRAM_LANE_W 8
`define SRAM_BURST_W 2
`define SRAM_FIFO_DEPTH 4
`define SRAM_DRIVE_RST 1'b0
`define SRAM_CNT_RST 2'h0
`endif

// ==== design/sram_port_pkg.sv ====
// Types shared by the pipelined burst SRAM port
`include "sram_port_defs.svh"
package sram_port_pkg;
    typedef struct packed
    {
        logic [`SRAM_LANES-1:0] par;
        logic [`SRAM_DATA_W-1:0] dat;
    } word_t;

    typedef struct packed
    {
        logic [`SRAM_ADDR_W-1:0] addr;
        logic [`SRAM_LANES-1:0] bw_n;
        word_t wd;
    } wr_cmd_t;

    typedef struct packed
    {
        logic vld;
        logic wr;
        logic [`SRAM_ADDR_W-1:0] addr;
        logic [`SRAM_LANES-1:0] bw_n;
    } stage_t;

    typedef enum logic [2:0]
    {
        BURST_IDLE = 3'b001,
        BURST_READ = 3'b010,
        BURST_WRITE = 3'b100
    } burst_st_t;
endpackage : sram_port_pkg

// ==== bench/bus_master_model.sv ====
// Bus master data stage that feeds write data to the SRAM port
`timescale 1ns/1ps
module bus_master_model
    import sram_port_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic adv_in,
    input wire logic wr_req_in,
    input wire word_t wr_word_in,
    output word_t data_out
);
    logic [2:0] vld_r;
    word_t [2:0] word_r;
    word_t idle_r;
    // Write data is driven two enabled edges after its command; a toggling pattern otherwise
    assign data_out = vld_r[2] ? word_r[2] : idle_r;
    always_ff @(posedge mclk_in)
    begin
        idle_r <= rst_in ? '0 : ~idle_r;
        if (rst_in)
            vld_r <= '0;
        else if (adv_in)
        begin
            vld_r <= {vld_r[1:0], wr_req_in};
            word_r <= {word_r[1:0], wr_word_in};
        end
    end
endmodule : bus_master_model

// ==== bench/pipelined_burst_sram_port_tb.sv ====
// Self-checking bench for the pipelined burst SRAM port
`timescale 1ns/1ps
module pipelined_burst_sram_port_tb
    import sram_port_pkg::*;
;
    typedef struct packed {logic drv; word_t w;} note_t;
    logic mclk_in = 0, rst_in = 1, rnw = 1, step = 0, clk_hold_n = 0, order = 0, odn = 0, wr_req = 0;
    logic cs_a_n = 1, cs_b_n = 1, cs_h = 0, oe_n, wq_rdy, adv, act = 0, dir_rd = 0;
    logic [16:0] addr = '0, base = '0;
    logic [3:0] bw_n = 4'hf;
    logic [1:0] k = '0;
    logic [36:0] last;
    word_t din, dout, wr_word = '0;
    word_t mem [logic [16:0]];
    note_t q[$];
    note_t nt;
    int fails = 0, n_compared = 0, i;
    logic [3:0] bws [7] = '{4'he, 4'hd, 4'hb, 4'h7, 4'h5, 4'h0, 4'hf};
    logic [2:0] css [4] = '{3'b101, 3'b011, 3'b000, 3'b111};

    initial forever #2.5 mclk_in = ~mclk_in;
    assign adv = !clk_hold_n && wq_rdy && !rst_in;

    pipelined_burst_sram_port dut_u
    (
        .mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr), .read_not_write_in(rnw),
        .step_or_load_sel_in(step), .clk_hold_n_in(clk_hold_n), .chip_select_low_a_in(cs_a_n),
        .chip_select_low_b_in(cs_b_n), .chip_select_high_in(cs_h), .byte_write_n_in(bw_n),
        .burst_order_sel_in(order), .output_drive_n_in(odn), .data_in(din), .data_out(dout),
        .data_oe_n_out(oe_n), .wq_ready_out(wq_rdy)
    );
    bus_master_model partner_u
    (
        .mclk_in(mclk_in), .rst_in(rst_in), .adv_in(adv), .wr_req_in(wr_req),
        .wr_word_in(wr_word), .data_out(din)
    );

    task automatic check(input logic [36:0] seen, input logic [36:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out

    // Oldest note falls due two enabled edges after its command
    always @(posedge mclk_in)
    begin
        #1;
        if (adv && q.size() > 2)
        begin
            nt = q.pop_front();
            nt.drv = nt.drv && !odn;
            check({oe_n, dout & {36{nt.drv}}}, {!nt.drv, nt.w & {36{nt.drv}}});
        end
        else if (!adv && !rst_in)
            check({oe_n, dout}, last);
        last = {oe_n, dout};
    end

    task automatic op(input logic s, input logic [2:0] cs, input logic r, input logic [16:0] a,
        input logic [3:0] bw);
        logic [16:0] ad;
        note_t n;
        word_t w;
        int t;
        @(negedge mclk_in);
        for (t = 0; wq_rdy !== 1'b1; t++)
        begin
            if (t == 20)
            begin
                fails++;
                close_out();
            end
            @(negedge mclk_in);
        end
        {cs_a_n, cs_b_n, cs_h} = cs;
        clk_hold_n = 0;
        step = s;
        rnw = r;
        addr = a;
        bw_n = bw;
        n = '0;
        wr_req = 0;
        w.dat = $urandom;
        w.par = 4'($urandom);
        if (!s)
        begin
            act = (cs == 3'b001);
            base = a;
            k = 2'h0;
            dir_rd = r;
        end
        else
            k = k + 2'h1;
        ad = {base[16:2], order ? base[1:0] ^ k : base[1:0] + k};
        if (act && dir_rd)
            n = {1'b1, mem[ad]};
        else if (act)
        begin
            wr_req = 1;
            wr_word = w;
            for (t = 0; t < 4; t++)
                if (!bw[t])
                begin
                    mem[ad].dat[8*t+:8] = w.dat[8*t+:8];
                    mem[ad].par[t] = w.par[t];
                end
        end
        q.push_back(n);
    endtask : op

    task automatic hold(input int c);
        repeat (c)
        begin
            @(negedge mclk_in);
            clk_hold_n = 1;
            step = 1'($urandom);
            addr = 17'($urandom);
            cs_h = 1'($urandom);
        end
    endtask : hold

    task automatic do_reset(input logic ord);
        @(negedge mclk_in);
        rst_in = 1;
        order = ord;
        clk_hold_n = 0;
        repeat (2) @(negedge mclk_in);
        check({35'h0, wq_rdy, oe_n}, {35'h0, 2'b11});
        check({oe_n, dout}, {1'b1, 36'h0});
        rst_in = 0;
        q.delete();
        act = 0;
    endtask : do_reset

    task automatic fin(input string s);
        op(0, 3'b111, 1, 17'h0, 4'hf);
        repeat (2) op(1, 3'b001, 0, 17'h0, 4'hf);
        $display("test %s done", s);
    endtask : fin

    initial
    begin
        void'($urandom(43));
        do_reset(0);
        op(0, 3'b001, 0, 17'h12, 4'h0);
        for (i = 0; i < 5; i++)
            op(1, 3'b010, i[0], 17'($urandom), 4'h0);
        fin("linear write burst");
        op(0, 3'b001, 1, 17'h11, 4'hf);
        op(1, 3'b001, 0, 17'h0, 4'h0);
        hold(3);
        repeat (4) op(1, 3'b001, 0, 17'h0, 4'h0);
        fin("linear read burst with held edges");
        foreach (bws[j])
        begin
            op(0, 3'b001, 0, 17'h13, bws[j]);
            op(0, 3'b001, 1, 17'h13, 4'hf);
        end
        fin("byte lanes");
        foreach (css[j])
        begin
            op(0, 3'b001, 1, 17'h10, 4'hf);
            op(1, 3'b001, 0, 17'h0, 4'hf);
            op(0, css[j], 1, 17'h12, 4'hf);
            op(1, 3'b001, 1, 17'h0, 4'hf);
        end
        fin("deselect");
        op(0, 3'b001, 1, 17'h10, 4'hf);
        odn = 1;
        #1 check({36'h0, oe_n}, {36'h0, 1'b1});
        repeat (3) op(1, 3'b001, 0, 17'h0, 4'hf);
        odn = 0;
        repeat (3) op(1, 3'b001, 0, 17'h0, 4'hf);
        fin("output drive");
        do_reset(1);
        op(0, 3'b001, 0, 17'h22, 4'h0);
        repeat (3) op(1, 3'b001, 1, 17'h0, 4'h0);
        op(0, 3'b001, 1, 17'h21, 4'hf);
        repeat (5) op(1, 3'b001, 0, 17'h0, 4'hf);
        fin("interleaved bursts");
        close_out();
    end
endmodule : pipelined_burst_sram_port_tb
